// ==== src/gate_stamp_pkg.sv ====
/*
 * Shared constants and types for the gate detector and timestamp store.
 * Assumes a single sample clock; register addresses are the plain indices
 * seen on the simple register port.
 */
package gate_stamp_pkg;

	// Register addresses on the plain register port.
	localparam int          ADDR_W            = 18;
	localparam logic [17:0] TS_CMD_ADDR       = 18'h0b798;
	localparam logic [17:0] TS_STATUS_ADDR    = 18'h0b7a2;
	localparam logic [17:0] TS_READOUT_ADDR   = 18'h0b7c0;
	localparam logic [17:0] GATE_EN_ADDR      = 18'h35cf0;
	localparam logic [17:0] GATE_MODE_ADDR    = 18'h3f000;
	localparam logic [17:0] PULSE_WIDTH_ADDR  = 18'h3f004;
	localparam logic [17:0] LEVEL_LO_ADDR     = 18'h3f008;
	localparam logic [17:0] LEVEL_HI_ADDR     = 18'h3f00c;

	// Codes written to and read from the timestamp command register.
	localparam logic [31:0] COUNTER_CLEAR_CMD        = 32'h00000000;
	localparam logic [31:0] STAMPING_OFF_CMD         = 32'h0000000a;
	localparam logic [31:0] CLEAR_ON_START_STAMP_CMD = 32'h0000000b;
	localparam logic [31:0] FREE_RUNNING_STAMP_CMD   = 32'h0000000c;

	// Store status codes.
	localparam logic [1:0] STORE_EMPTY       = 2'h0;
	localparam logic [1:0] STORE_BELOW_HALF  = 2'h1;
	localparam logic [1:0] STORE_ABOVE_HALF  = 2'h2;
	localparam logic [1:0] STAMP_STORE_OVERRUN = 2'h3;

	// Sizes and timing.
	localparam int STAMP_W      = 64;
	localparam int STORE_AW     = 16;
	localparam int ALIGN_LOG2   = 3;
	localparam int SAMPLE_W     = 16;
	localparam int WIDTH_W      = 32;

	// Reset values of the configuration registers.
	localparam logic [31:0] PULSE_WIDTH_RST = 32'h00000000;
	localparam logic [15:0] LEVEL_LO_RST    = 16'h0000;
	localparam logic [15:0] LEVEL_HI_RST    = 16'h0000;

	typedef enum logic [3:0] {
		ext_rise_gate_mode              = 4'h0,
		ext_fall_gate_mode              = 4'h1,
		ext_high_width_gate_mode        = 4'h2,
		ext_low_width_gate_mode         = 4'h3,
		chan_rise_gate_mode             = 4'h4,
		chan_fall_gate_mode             = 4'h5,
		chan_high_width_gate_mode       = 4'h6,
		chan_low_width_gate_mode        = 4'h7,
		chan_band_enter_gate_mode       = 4'h8,
		chan_band_enter_width_gate_mode = 4'h9,
		chan_band_exit_gate_mode        = 4'ha,
		chan_band_exit_width_gate_mode  = 4'hb
	} gate_mode_t;

	typedef enum logic [2:0] {
		STAMP_OFF       = 3'b001,
		STAMP_FREE      = 3'b010,
		STAMP_START_CLR = 3'b100
	} stamp_mode_t;

	typedef enum logic [2:0] {
		GATE_IDLE    = 3'b001,
		GATE_OPEN    = 3'b010,
		GATE_CLOSING = 3'b100
	} gate_state_t;

endpackage : gate_stamp_pkg

// ==== src/stamp_store_if.sv ====
/*
 * Carrier between the gate detector and the timestamp store.
 * Assumes both ends run on the same sample clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface stamp_store_if #(
	parameter int DATA_W = gate_stamp_pkg::STAMP_W,
	parameter int AW     = gate_stamp_pkg::STORE_AW
);
	logic              push_valid;
	logic              push_ready;
	logic [DATA_W-1:0] push_data;
	logic              pop;
	logic [DATA_W-1:0] head_data;
	logic              empty;
	logic              full;
	logic [AW:0]       level;

	modport producer (output push_valid, push_data, pop,
		input push_ready, head_data, empty, full, level);
	modport store (input push_valid, push_data, pop,
		output push_ready, head_data, empty, full, level);
endinterface : stamp_store_if

`default_nettype wire

// ==== src/stamp_store.sv ====
/*
 * First-in first-out store for timestamps.
 * Assumes the producer never pops while empty; such a pop is ignored.
 */
`timescale 1ns/100ps
`default_nettype none

module stamp_store (
	// Clock and reset.
	input  wire logic      clock_in,
	input  wire logic      rst_n_in,
	// Store side of the carrier.
	stamp_store_if.store   st
);
	localparam int AW = $bits(st.level) - 1;
	localparam int DW = $bits(st.push_data);

	typedef struct packed {
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} store_state_t;

	store_state_t        s_q;
	store_state_t        s_d;
	logic [DW-1:0]       mem [0:(1<<AW)-1];
	logic                do_push;

	assign st.level      = s_q.wr_ptr - s_q.rd_ptr;
	assign st.empty      = (s_q.wr_ptr == s_q.rd_ptr);
	assign st.full       = (st.level[AW] == 1'b1);
	assign st.push_ready = !st.full;
	assign st.head_data  = mem[s_q.rd_ptr[AW-1:0]];
	assign do_push       = st.push_valid && !st.full;

	always_comb begin
		s_d = s_q;
		if (do_push) begin
			s_d.wr_ptr = s_q.wr_ptr + 1'b1;
		end
		if (st.pop && !st.empty) begin
			s_d.rd_ptr = s_q.rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// The array has no reset so that it can map onto block memory.
	always_ff @(posedge clock_in) begin
		if (do_push) begin
			mem[s_q.wr_ptr[AW-1:0]] <= st.push_data;
		end
	end

endmodule : stamp_store

`default_nettype wire

// ==== src/gate_event_timestamper.sv ====
/*
 * Gate start/end detector with a sample-clocked timestamp counter and store.
 * Assumes clock_in is the non-interlaced sample clock, the channel sample and
 * board start come from logic on the same clock, and the trigger is a pin.
 */
// Decided for this implementation: the plain strobed port.
// Summary of operation
// - Trigger edge gate: open edge, close opposite
// - Trigger high longer than width opens gate
// - Trigger low longer than width opens gate
// - Channel level crossings open and close gate
// - Channel above level long enough opens gate
// - Channel below level long enough opens gate
// - Entering band opens, leaving band closes
// - Leaving band opens, re-entering band closes
// - Width-qualified band entry opens gate
// - Width-qualified band exit opens gate
// - Sample counter copied to store per trigger
// - Gated mode stamps segment start and end
// - Stamps kept in 64K FIFO, readable live
// - Stamp equals samples since last clear
// - Counter runs at base sample clock, 125MS/s
// - Command write executes, read returns mode
// - Command zero clears the counter
// - Command ten disables stamping entirely
// - Command twelve: clear only by command
// - Command eleven: clear on every board start
// - Gating enabled by its own register
// - Gate end recognised on eight-sample boundary
// - Readout port gives 32 bits, zero if empty
// - Status code three when full or lost
`timescale 1ns/100ps
`default_nettype none

module gate_event_timestamper #(
	parameter int STORE_AW = gate_stamp_pkg::STORE_AW
) (
	// Clock and reset.
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	// Register port.
	input  wire logic [17:0] reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	// Trigger sources and board control.
	input  wire logic        ext_trig_in,
	input  wire logic [15:0] chan_sample_in,
	input  wire logic        board_start_in,
	// Gate and stamp observation.
	output logic             gate_open_out,
	output logic             stamp_strobe_out,
	output logic      [63:0] timestamp_out
);
	localparam int SW = gate_stamp_pkg::STAMP_W;
	localparam int AL = gate_stamp_pkg::ALIGN_LOG2;

	typedef struct packed {
		logic                              ext_sync1;
		logic                              ext_sync2;
		logic                              cond_prev;
		logic [gate_stamp_pkg::WIDTH_W-1:0] cond_len;
		gate_stamp_pkg::gate_state_t       gate_state;
		logic [AL-1:0]                     align_pos;
		gate_stamp_pkg::stamp_mode_t       stamp_mode;
		logic                              gating_enable;
		gate_stamp_pkg::gate_mode_t        gate_mode;
		logic [gate_stamp_pkg::WIDTH_W-1:0] pulse_width;
		logic [gate_stamp_pkg::SAMPLE_W-1:0] level_lo;
		logic [gate_stamp_pkg::SAMPLE_W-1:0] level_hi;
		logic [SW-1:0]                     counter;
		logic                              overrun;
		logic                              high_half;
		logic [31:0]                       rdata;
		logic                              stamp_strobe;
		logic [SW-1:0]                     stamp_value;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;

	stamp_store_if #(.DATA_W(SW), .AW(STORE_AW)) store_bus ();

	stamp_store u_store (
		.clock_in (clock_in),
		.rst_n_in (rst_n_in),
		.st       (store_bus.store)
	);

	// Width-qualified modes open on a held level instead of an edge.
	function automatic logic is_width_mode(
		input gate_stamp_pkg::gate_mode_t m
	);
		is_width_mode = (m == gate_stamp_pkg::ext_high_width_gate_mode) ||
			(m == gate_stamp_pkg::ext_low_width_gate_mode) ||
			(m == gate_stamp_pkg::chan_high_width_gate_mode) ||
			(m == gate_stamp_pkg::chan_low_width_gate_mode) ||
			(m == gate_stamp_pkg::chan_band_enter_width_gate_mode) ||
			(m == gate_stamp_pkg::chan_band_exit_width_gate_mode);
	endfunction : is_width_mode

	function automatic logic [31:0] mode_code(
		input gate_stamp_pkg::stamp_mode_t m
	);
		unique case (m)
			gate_stamp_pkg::STAMP_FREE:
				mode_code = gate_stamp_pkg::FREE_RUNNING_STAMP_CMD;
			gate_stamp_pkg::STAMP_START_CLR:
				mode_code = gate_stamp_pkg::CLEAR_ON_START_STAMP_CMD;
			default:
				mode_code = gate_stamp_pkg::STAMPING_OFF_CMD;
		endcase
	endfunction : mode_code

	logic cond;
	logic above;
	logic in_band;
	logic open_evt;
	logic stamp_evt;
	logic clear_cmd;
	logic wr_hit;
	logic rd_hit;

	assign store_bus.push_valid = stamp_evt &&
		(s_q.stamp_mode != gate_stamp_pkg::STAMP_OFF);
	assign store_bus.push_data  = s_q.counter;
	assign store_bus.pop        = reg_rd_in &&
		(reg_addr_in == gate_stamp_pkg::TS_READOUT_ADDR) && s_q.high_half;

	assign reg_rdata_out    = s_q.rdata;
	assign gate_open_out    = (s_q.gate_state != gate_stamp_pkg::GATE_IDLE);
	assign stamp_strobe_out = s_q.stamp_strobe;
	assign timestamp_out    = s_q.stamp_value;

	always_comb begin
		s_d       = s_q;
		above     = 1'b0;
		in_band   = 1'b0;
		cond      = 1'b0;
		open_evt  = 1'b0;
		stamp_evt = 1'b0;
		clear_cmd = 1'b0;
		wr_hit    = 1'b0;
		rd_hit    = 1'b0;

		// The trigger pin crosses into the sample clock before any use.
		s_d.ext_sync1 = ext_trig_in;
		s_d.ext_sync2 = s_q.ext_sync1;

		above   = $signed(chan_sample_in) > $signed(s_q.level_lo);
		in_band = ($signed(chan_sample_in) > $signed(s_q.level_lo)) &&
			($signed(chan_sample_in) < $signed(s_q.level_hi));

		// Each mode reduces to one level; its rise, or in width modes its hold, opens and its fall closes.
		unique case (s_q.gate_mode)
			gate_stamp_pkg::ext_rise_gate_mode:
				cond = s_q.ext_sync2;
			gate_stamp_pkg::ext_fall_gate_mode:
				cond = !s_q.ext_sync2;
			gate_stamp_pkg::ext_high_width_gate_mode:
				cond = s_q.ext_sync2;
			gate_stamp_pkg::ext_low_width_gate_mode:
				cond = !s_q.ext_sync2;
			gate_stamp_pkg::chan_rise_gate_mode:
				cond = above;
			gate_stamp_pkg::chan_fall_gate_mode:
				cond = !above;
			gate_stamp_pkg::chan_high_width_gate_mode:
				cond = above;
			gate_stamp_pkg::chan_low_width_gate_mode:
				cond = !above;
			gate_stamp_pkg::chan_band_enter_gate_mode:
				cond = in_band;
			gate_stamp_pkg::chan_band_enter_width_gate_mode:
				cond = in_band;
			gate_stamp_pkg::chan_band_exit_gate_mode:
				cond = !in_band;
			gate_stamp_pkg::chan_band_exit_width_gate_mode:
				cond = !in_band;
			default:
				cond = 1'b0;
		endcase

		s_d.cond_prev = cond;
		if (!cond) begin
			s_d.cond_len = '0;
		end else if (s_q.cond_len != '1) begin
			s_d.cond_len = s_q.cond_len + 1'b1;
		end

		// A held level fires once, when it has lasted width plus one samples.
		if (is_width_mode(s_q.gate_mode)) begin
			open_evt = cond &&
				(s_q.cond_len == s_q.pulse_width);
		end else begin
			open_evt = cond && !s_q.cond_prev;
		end

		s_d.align_pos = s_q.align_pos + 1'b1;
		unique case (s_q.gate_state)
			gate_stamp_pkg::GATE_IDLE: begin
				s_d.align_pos = '0;
				if (s_q.gating_enable && open_evt) begin
					s_d.gate_state = gate_stamp_pkg::GATE_OPEN;
					stamp_evt      = 1'b1;
				end else if (!s_q.gating_enable && open_evt) begin
					stamp_evt = 1'b1;
				end
			end
			gate_stamp_pkg::GATE_OPEN: begin
				if (!s_q.gating_enable) begin
					s_d.gate_state = gate_stamp_pkg::GATE_IDLE;
				end else if (!cond) begin
					// The end only lands on the last sample of a block.
					if (s_q.align_pos == '1) begin
						s_d.gate_state = gate_stamp_pkg::GATE_IDLE;
						stamp_evt      = 1'b1;
					end else begin
						s_d.gate_state = gate_stamp_pkg::GATE_CLOSING;
					end
				end
			end
			gate_stamp_pkg::GATE_CLOSING: begin
				if (!s_q.gating_enable) begin
					s_d.gate_state = gate_stamp_pkg::GATE_IDLE;
				end else if (s_q.align_pos == '1) begin
					s_d.gate_state = gate_stamp_pkg::GATE_IDLE;
					stamp_evt      = 1'b1;
				end
			end
			default: begin
				s_d.gate_state = gate_stamp_pkg::GATE_IDLE;
			end
		endcase

		s_d.stamp_strobe = store_bus.push_valid && store_bus.push_ready;
		if (store_bus.push_valid && store_bus.push_ready) begin
			s_d.stamp_value = s_q.counter;
		end

		// Register writes.
		wr_hit = reg_wr_in;
		if (wr_hit) begin
			unique case (reg_addr_in)
				gate_stamp_pkg::TS_CMD_ADDR: begin
					unique case (reg_wdata_in)
						gate_stamp_pkg::COUNTER_CLEAR_CMD:
							clear_cmd = 1'b1;
						gate_stamp_pkg::STAMPING_OFF_CMD:
							s_d.stamp_mode = gate_stamp_pkg::STAMP_OFF;
						gate_stamp_pkg::CLEAR_ON_START_STAMP_CMD:
							s_d.stamp_mode = gate_stamp_pkg::STAMP_START_CLR;
						gate_stamp_pkg::FREE_RUNNING_STAMP_CMD:
							s_d.stamp_mode = gate_stamp_pkg::STAMP_FREE;
						default: begin
						end
					endcase
				end
				gate_stamp_pkg::GATE_EN_ADDR:
					s_d.gating_enable = reg_wdata_in[0];
				gate_stamp_pkg::GATE_MODE_ADDR:
					s_d.gate_mode = gate_stamp_pkg::gate_mode_t'(reg_wdata_in[3:0]);
				gate_stamp_pkg::PULSE_WIDTH_ADDR:
					s_d.pulse_width = reg_wdata_in;
				gate_stamp_pkg::LEVEL_LO_ADDR:
					s_d.level_lo = reg_wdata_in[15:0];
				gate_stamp_pkg::LEVEL_HI_ADDR:
					s_d.level_hi = reg_wdata_in[15:0];
				default: begin
				end
			endcase
		end

		// One count per base sample clock; a clear makes the next value zero.
		s_d.counter = s_q.counter + 64'h1;
		if (clear_cmd || (board_start_in &&
			s_q.stamp_mode == gate_stamp_pkg::STAMP_START_CLR)) begin
			s_d.counter = '0;
		end

		// Overrun is sticky; a loss in the clearing cycle still sets it.
		if (clear_cmd) begin
			s_d.overrun = 1'b0;
		end
		if (store_bus.push_valid && !store_bus.push_ready) begin
			s_d.overrun = 1'b1;
		end

		// Register reads; data stand in the following cycle only.
		rd_hit  = reg_rd_in;
		s_d.rdata = 32'h00000000;
		if (rd_hit) begin
			unique case (reg_addr_in)
				gate_stamp_pkg::TS_CMD_ADDR:
					s_d.rdata = mode_code(s_q.stamp_mode);
				gate_stamp_pkg::TS_STATUS_ADDR: begin
					if (s_q.overrun || store_bus.full) begin
						s_d.rdata = {30'h0, gate_stamp_pkg::STAMP_STORE_OVERRUN};
					end else if (store_bus.empty) begin
						s_d.rdata = {30'h0, gate_stamp_pkg::STORE_EMPTY};
					end else if (store_bus.level[STORE_AW-1] == 1'b0) begin
						s_d.rdata = {30'h0, gate_stamp_pkg::STORE_BELOW_HALF};
					end else begin
						s_d.rdata = {30'h0, gate_stamp_pkg::STORE_ABOVE_HALF};
					end
				end
				gate_stamp_pkg::TS_READOUT_ADDR: begin
					// Low word first, then high word, which retires the entry.
					if (store_bus.empty) begin
						s_d.rdata     = 32'h00000000;
						s_d.high_half = 1'b0;
					end else if (!s_q.high_half) begin
						s_d.rdata     = store_bus.head_data[31:0];
						s_d.high_half = 1'b1;
					end else begin
						s_d.rdata     = store_bus.head_data[63:32];
						s_d.high_half = 1'b0;
					end
				end
				gate_stamp_pkg::GATE_EN_ADDR:
					s_d.rdata = {31'h0, s_q.gating_enable};
				gate_stamp_pkg::GATE_MODE_ADDR:
					s_d.rdata = {28'h0, s_q.gate_mode};
				gate_stamp_pkg::PULSE_WIDTH_ADDR:
					s_d.rdata = s_q.pulse_width;
				gate_stamp_pkg::LEVEL_LO_ADDR:
					s_d.rdata = {16'h0, s_q.level_lo};
				gate_stamp_pkg::LEVEL_HI_ADDR:
					s_d.rdata = {16'h0, s_q.level_hi};
				default:
					s_d.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q               <= '0;
			s_q.gate_state    <= gate_stamp_pkg::GATE_IDLE;
			s_q.stamp_mode    <= gate_stamp_pkg::STAMP_OFF;
			s_q.gate_mode     <= gate_stamp_pkg::ext_rise_gate_mode;
			s_q.pulse_width   <= gate_stamp_pkg::PULSE_WIDTH_RST;
			s_q.level_lo      <= gate_stamp_pkg::LEVEL_LO_RST;
			s_q.level_hi      <= gate_stamp_pkg::LEVEL_HI_RST;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : gate_event_timestamper

`default_nettype wire

// ==== sim/gate_event_timestamper_sva.sv ====
/* Assertions on the top ports of the gate and timestamp block.
   Assumes one-cycle register strobes that never overlap. */
`timescale 1ns/100ps
`default_nettype none
module gate_event_timestamper_sva #(
	parameter int STORE_AW = 16
) (
	// Clock and reset.
	input wire logic        clock_in,
	input wire logic        rst_n_in,
	// Register port.
	input wire logic [17:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	// Trigger sources.
	input wire logic        ext_trig_in,
	input wire logic [15:0] chan_sample_in,
	input wire logic        board_start_in,
	// Observation.
	input wire logic        gate_open_out,
	input wire logic        stamp_strobe_out,
	input wire logic [63:0] timestamp_out
);
	logic [31:0] mode_q;
	logic        gate_en_q;
	logic [31:0] open_cnt_q;
	logic [STORE_AW:0] fill_q;
	logic [STORE_AW:0] fill_now;
	logic        hi_q;
	logic        rd_out;
	logic        rd_stat;
	// A strobe trails its push by one cycle, so the live fill adds it in.
	assign fill_now = fill_q + {{STORE_AW{1'b0}}, stamp_strobe_out};
	assign rd_out   = reg_rd_in &&
		reg_addr_in == gate_stamp_pkg::TS_READOUT_ADDR;
	assign rd_stat  = reg_rd_in &&
		reg_addr_in == gate_stamp_pkg::TS_STATUS_ADDR;
	// Mirrors of the mode and enable let reads be tied to the last write.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_q     <= gate_stamp_pkg::STAMPING_OFF_CMD;
			gate_en_q  <= 1'b0;
			open_cnt_q <= 32'h0;
			fill_q     <= '0;
			hi_q       <= 1'b0;
		end else begin
			if (reg_wr_in && reg_addr_in == gate_stamp_pkg::TS_CMD_ADDR &&
				reg_wdata_in inside {32'ha, 32'hb, 32'hc})
				mode_q <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == gate_stamp_pkg::GATE_EN_ADDR)
				gate_en_q <= reg_wdata_in[0];
			open_cnt_q <= gate_open_out ? open_cnt_q + 32'h1 : 32'h0;
			fill_q <= (rd_out && hi_q && fill_now != '0) ?
				fill_now - 1'b1 : fill_now;
			if (rd_out)
				hi_q <= (fill_now != '0) && !hi_q;
		end
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	rdata_idle_a: assert property (
		!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data not zero outside a read answer");
	mode_read_a: assert property (
		reg_rd_in && reg_addr_in == 18'h0b798 |=> reg_rdata_out == mode_q)
		else $error("command read does not return the mode");
	gate_en_read_a: assert property (
		reg_rd_in && reg_addr_in == 18'h35cf0 |=>
		reg_rdata_out == {31'h0, gate_en_q})
		else $error("gating enable read mismatch");
	status_range_a: assert property (
		rd_stat |=> reg_rdata_out[31:2] == 30'h0)
		else $error("status code out of range");
	stamp_hold_a: assert property (
		!stamp_strobe_out |-> $stable(timestamp_out))
		else $error("timestamp moved without a strobe");
	off_quiet_a: assert property (
		mode_q == 32'ha && $past(mode_q) == 32'ha |-> !stamp_strobe_out)
		else $error("stamp stored while stamping is off");
	open_stamp_a: assert property (
		$rose(gate_open_out) && $past(gate_en_q) &&
		$past(mode_q) != 32'ha && !$past(fill_now[STORE_AW]) |->
		stamp_strobe_out)
		else $error("gate start without a stamp");
	close_align_a: assert property (
		$fell(gate_open_out) && gate_en_q && $past(gate_en_q) |->
		open_cnt_q[2:0] == 3'h0)
		else $error("gate end off the eight sample boundary");
	empty_read_a: assert property (
		rd_out && fill_now == '0 |=> reg_rdata_out == 32'h0)
		else $error("readout of an empty store not zero");
	fill_status_a: assert property (
		rd_stat && fill_now != '0 |=> reg_rdata_out != 32'h0)
		else $error("status empty while stamps are stored");
	full_status_a: assert property (
		rd_stat && fill_now[STORE_AW] |=> reg_rdata_out == 32'h3)
		else $error("status not full with a full store");
	cover property ($rose(gate_open_out));
	cover property (stamp_strobe_out && gate_en_q);
	cover property (rd_stat ##1 reg_rdata_out == 32'h3);
endmodule : gate_event_timestamper_sva
bind gate_event_timestamper gate_event_timestamper_sva #(.STORE_AW(STORE_AW)) chk (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .ext_trig_in(ext_trig_in),
	.chan_sample_in(chan_sample_in), .board_start_in(board_start_in),
	.gate_open_out(gate_open_out), .stamp_strobe_out(stamp_strobe_out),
	.timestamp_out(timestamp_out));
`default_nettype wire

// ==== sim/sig_source.sv ====
/* Model of the trigger pin and the analog channel feeding the block.
   Assumes levels of 0x64 and 0x3e8 are programmed in the block. */
`timescale 1ns/100ps
`default_nettype none
module sig_source (
	// Clock.
	input  wire logic        clock_in,
	// Trigger pin and channel samples.
	output var  logic        ext_trig_out,
	output var  logic [15:0] chan_sample_out
);
	initial begin
		ext_trig_out = 1'b0;
		chan_sample_out = 16'h0000;
	end
	// Drives the gate condition of a mode true or false for some cycles.
	task automatic drive(input logic [3:0] mode, input logic on,
		input logic [7:0] r, input int cycles);
		logic act;
		act = on ^ mode[0];
		@(posedge clock_in);
		ext_trig_out <= (mode < 4'h4) ? act : 1'b0;
		if (mode < 4'h8)
			chan_sample_out <= act ? 16'h0065 + r : 16'h0064 - r;
		else
			chan_sample_out <= (on ^ mode[1]) ? 16'h0065 + r : 16'h03e8 + r;
		repeat (cycles - 1) @(posedge clock_in);
	endtask : drive
endmodule : sig_source
`default_nettype wire

// ==== sim/test_gate_event_timestamper.sv ====
/* Self-checking bench for the gate and timestamp block.
   Assumes the checker is bound to the block and a sixteen entry deep store. */
`timescale 1ns/100ps
`default_nettype none
module test_gate_event_timestamper;
	logic        clock_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [17:0] reg_addr_in = 18'h0;
	logic [31:0] reg_wdata_in = 32'h0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic        board_start_in = 1'b0;
	logic [31:0] reg_rdata_out, mode_q, rd, base;
	logic [31:0] seed = 32'h20143f2b;
	logic [31:0] strobes = 32'h0;
	logic        ext_trig_in, gate_open_out, stamp_strobe_out;
	logic [15:0] chan_sample_in;
	logic [63:0] timestamp_out, ref_q;
	logic [63:0] stamps_q[$];
	int          num_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	logic        cmd_wr;
	assign cmd_wr = reg_wr_in && reg_addr_in == gate_stamp_pkg::TS_CMD_ADDR;
	always #4 clock_in = ~clock_in;
	gate_event_timestamper #(.STORE_AW(4)) dut (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.ext_trig_in(ext_trig_in), .chan_sample_in(chan_sample_in),
		.board_start_in(board_start_in), .gate_open_out(gate_open_out),
		.stamp_strobe_out(stamp_strobe_out), .timestamp_out(timestamp_out));
	sig_source src (.clock_in(clock_in), .ext_trig_out(ext_trig_in),
		.chan_sample_out(chan_sample_in));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [63:0] exp_stamps(input logic g,
		input logic [31:0] c);
		if (c == gate_stamp_pkg::STAMPING_OFF_CMD)
			return 64'h0;
		return g ? 64'h2 : 64'h1;
	endfunction : exp_stamps
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Reference counter: cleared by the clear command or by a start in mode 11.
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ref_q <= 64'h0;
			mode_q <= gate_stamp_pkg::STAMPING_OFF_CMD;
		end else begin
			ref_q <= ((cmd_wr && reg_wdata_in == 32'h0) ||
				(board_start_in && mode_q == 32'hb)) ? 64'h0 :
				ref_q + 64'h1;
			if (cmd_wr && reg_wdata_in inside {32'ha, 32'hb, 32'hc})
				mode_q <= reg_wdata_in;
			if (stamp_strobe_out) begin
				check(timestamp_out, ref_q - 64'h1);
				stamps_q.push_back(ref_q - 64'h1);
				strobes <= strobes + 32'h1;
			end
			cyc++;
			if (cyc == 12000) begin
				num_errors++;
				final_report();
			end
		end
	end
	task automatic reg_wr(input logic [17:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask : reg_wr
	task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp);
		@(posedge clock_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		#1 rd = reg_rdata_out;
		check({32'h0, rd}, {32'h0, exp});
	endtask : rd_chk
	task automatic set_cmd(input logic [31:0] c);
		reg_wr(gate_stamp_pkg::TS_CMD_ADDR, c);
		rd_chk(gate_stamp_pkg::TS_CMD_ADDR, c == 32'h0 ? mode_q : c);
	endtask : set_cmd
	task automatic start_pulse();
		@(posedge clock_in);
		board_start_in <= 1'b1;
		@(posedge clock_in);
		board_start_in <= 1'b0;
	endtask : start_pulse
	task automatic drain();
		logic [63:0] e;
		while (stamps_q.size() > 0) begin
			e = stamps_q.pop_front();
			rd_chk(gate_stamp_pkg::TS_READOUT_ADDR, e[31:0]);
			rd_chk(gate_stamp_pkg::TS_READOUT_ADDR, e[63:32]);
		end
		rd_chk(gate_stamp_pkg::TS_READOUT_ADDR, 32'h0);
	endtask : drain
	initial begin
		repeat (6) @(posedge clock_in);
		rst_n_in <= 1'b1;
		rd_chk(gate_stamp_pkg::TS_CMD_ADDR, 32'ha);
		rd_chk(gate_stamp_pkg::TS_STATUS_ADDR, 32'h0);
		rd_chk(18'h00001, 32'h0);
		reg_wr(gate_stamp_pkg::PULSE_WIDTH_ADDR, 32'h2);
		reg_wr(gate_stamp_pkg::LEVEL_LO_ADDR, 32'h64);
		reg_wr(gate_stamp_pkg::LEVEL_HI_ADDR, 32'h3e8);
		reg_wr(gate_stamp_pkg::GATE_EN_ADDR, 32'h1);
		rd_chk(gate_stamp_pkg::GATE_EN_ADDR, 32'h1);
		for (int m = 0; m < 12; m++) begin
			set_cmd(gate_stamp_pkg::STAMPING_OFF_CMD);
			reg_wr(gate_stamp_pkg::GATE_MODE_ADDR, 32'(m));
			src.drive(4'(m), 1'b0, 8'h0, 20);
			set_cmd(gate_stamp_pkg::FREE_RUNNING_STAMP_CMD);
			start_pulse();
			base = strobes;
			seed = lfsr(seed);
			// A pulse exactly as long as the width must not open the gate.
			if (m inside {2, 3, 6, 7, 9, 11}) begin
				src.drive(4'(m), 1'b1, seed[7:0], 2);
				src.drive(4'(m), 1'b0, seed[7:0], 20);
				check({32'h0, strobes - base}, 64'h0);
			end
			src.drive(4'(m), 1'b1, seed[7:0], 12 + seed[11:8]);
			src.drive(4'(m), 1'b0, seed[7:0], 30);
			check({32'h0, strobes - base}, exp_stamps(1'b1, 32'hc));
			rd_chk(gate_stamp_pkg::TS_STATUS_ADDR, 32'h1);
			drain();
		end
		reg_wr(gate_stamp_pkg::GATE_EN_ADDR, 32'h0);
		reg_wr(gate_stamp_pkg::GATE_MODE_ADDR, 32'h0);
		src.drive(4'h0, 1'b0, 8'h0, 20);
		for (int k = 0; k < 3; k++) begin
			set_cmd(32'ha + 32'(k));
			start_pulse();
			base = strobes;
			src.drive(4'h0, 1'b1, 8'h0, 8);
			src.drive(4'h0, 1'b0, 8'h0, 16);
			check({32'h0, strobes - base}, exp_stamps(1'b0, 32'ha + 32'(k)));
		end
		drain();
		set_cmd(gate_stamp_pkg::COUNTER_CLEAR_CMD);
		base = strobes;
		for (int p = 0; p < 17; p++) begin
			seed = lfsr(seed);
			src.drive(4'h0, 1'b1, 8'h0, 4 + seed[1:0]);
			src.drive(4'h0, 1'b0, 8'h0, 12);
		end
		check({32'h0, strobes - base}, 64'h10);
		rd_chk(gate_stamp_pkg::TS_STATUS_ADDR, 32'h3);
		drain();
		set_cmd(gate_stamp_pkg::COUNTER_CLEAR_CMD);
		rd_chk(gate_stamp_pkg::TS_STATUS_ADDR, 32'h0);
		final_report();
	end
endmodule : test_gate_event_timestamper
`default_nettype wire
